// *** led_scan_pkg.sv ***
/*
  Constants, field layouts and carrier types for the multiplexed LED scan
  controller. Assumes a 100 MHz system clock.
*/
package led_scan_pkg;
  // Command codes of the 16-bit command word
  localparam logic [7:0] CMD_NOOP = 8'h00;
  localparam logic [7:0] CMD_DECODE = 8'h01;
  localparam logic [7:0] CMD_INTENSITY = 8'h02;
  localparam logic [7:0] CMD_SCAN_LIMIT = 8'h03;
  localparam logic [7:0] CMD_CONFIG = 8'h04;
  localparam logic [7:0] CMD_TEST = 8'h07;
  localparam logic [4:0] CMD_PLANE0_BASE = 5'h04;  // 0x20-0x27, upper five bits
  localparam logic [4:0] CMD_PLANE1_BASE = 5'h08;  // 0x40-0x47
  localparam logic [4:0] CMD_BOTH_BASE = 5'h0c;    // 0x60-0x67

  // Values after reset
  localparam logic [7:0] DECODE_RST = 8'h00;
  localparam logic [3:0] INTENSITY_RST = 4'h0;
  localparam logic [2:0] SCAN_LIMIT_RST = 3'h4;
  localparam logic [7:0] CONFIG_RST = 8'h00;

  // Duty in sixteenths
  localparam logic [3:0] DUTY_MAX = 4'hf;
  localparam logic [3:0] DUTY_TEST = 4'h7;
  localparam int DUTY_STEPS = 16;

  // Time base
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int RC_OSC_HZ = 4_000_000;
  localparam int RC_DIV_CYCLES = SYS_CLK_HZ / RC_OSC_HZ;
  localparam int FAILSAFE_HZ = 75_500;
  // Longest allowed gap between multiplex ticks, rounded down
  localparam int FAILSAFE_CYCLES = SYS_CLK_HZ / FAILSAFE_HZ;
  localparam int DIGIT_TIME_US = 200;
  localparam int DIGIT_TICKS = DIGIT_TIME_US * (RC_OSC_HZ / 1_000_000);
  localparam int BLINK_SLOW_MS = 1000;
  localparam int BLINK_FAST_MS = 500;
  localparam int BLINK_SLOW_TICKS = BLINK_SLOW_MS * (RC_OSC_HZ / 1000);
  localparam int BLINK_FAST_TICKS = BLINK_FAST_MS * (RC_OSC_HZ / 1000);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cmd_word_t;

  typedef struct packed {
    logic [1:0] unused;
    logic global_clear;
    logic timing_reset;
    logic blink_en;
    logic blink_fast;
    logic fixed_zero;
    logic run;
  } config_t;
endpackage

// *** hex_font_decode.sv ***
/*
  Hexadecimal seven-segment font, segments a..g with a in the top bit.
  Purely combinational; the caller supplies the decimal point itself.
*/
`timescale 1ns/1ps
`default_nettype none
module hex_font_decode (
  input wire logic [3:0] i_nibble,
  output logic [6:0] o_segments
);
  function automatic logic [6:0] font(input logic [3:0] n);
    unique case (n)
      4'h0: font = 7'h7e;
      4'h1: font = 7'h30;
      4'h2: font = 7'h6d;
      4'h3: font = 7'h79;
      4'h4: font = 7'h33;
      4'h5: font = 7'h5b;
      4'h6: font = 7'h5f;
      4'h7: font = 7'h70;
      4'h8: font = 7'h7f;
      4'h9: font = 7'h7b;
      4'ha: font = 7'h77;
      4'hb: font = 7'h1f;
      4'hc: font = 7'h4e;
      4'hd: font = 7'h3f;
      4'he: font = 7'h4f;
      4'hf: font = 7'h47;
    endcase
  endfunction

  assign o_segments = font(i_nibble);
endmodule
`default_nettype wire

// *** mux_clock_source.sv ***
/*
  Multiplex tick source: internal divider standing in for the RC oscillator,
  or rising edges of the external clock pin, with a dead-clock fill-in.
  The external pin is taken as synchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mux_clock_source #(
  parameter int RC_DIV = led_scan_pkg::RC_DIV_CYCLES,
  parameter int FAILSAFE = led_scan_pkg::FAILSAFE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_multiplex_clock_input,
  input wire logic i_use_external,
  output logic o_osc_tick
);
  localparam int DW = $clog2(RC_DIV);
  localparam int GW = $clog2(FAILSAFE + 1);

  logic [DW-1:0] div_r;
  logic pin_prev_r;
  logic [GW-1:0] gap_r;
  logic src_tick;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_r <= '0;
    end else if (div_r == DW'(RC_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= i_multiplex_clock_input;
    end
  end

  assign src_tick = i_use_external ? (i_multiplex_clock_input & ~pin_prev_r) : (div_r == DW'(RC_DIV - 1));
  // A stuck source must never freeze the scan on one digit
  assign o_osc_tick = src_tick | (gap_r == GW'(FAILSAFE - 1));

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_r <= '0;
    end else if (o_osc_tick) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end

  property p_failsafe_gap;
    @(posedge i_clock) disable iff (i_sys_rst) gap_r <= GW'(FAILSAFE - 1);
  endproperty
  a_failsafe_gap: assert property (p_failsafe_gap) else $error("Multiplex tick gap too long");
endmodule
`default_nettype wire

// *** led_scan_ctrl.sv ***
/*
  Register file, two-plane digit storage and multiplex scan of an
  eight-digit seven-segment LED driver. Command words arrive already
  shifted in; i_cs_rise marks the chip-select rising edge that applies one.
  Digit strobes and segment lines feed the analog drivers outside.
*/
`timescale 1ns/1ps
`default_nettype none
module led_scan_ctrl #(
  parameter int DIGIT_TICKS = led_scan_pkg::DIGIT_TICKS,
  parameter int SLOW_TICKS = led_scan_pkg::BLINK_SLOW_TICKS,
  parameter int FAST_TICKS = led_scan_pkg::BLINK_FAST_TICKS,
  parameter int RC_DIV = led_scan_pkg::RC_DIV_CYCLES,
  parameter int FAILSAFE = led_scan_pkg::FAILSAFE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_cs_rise,
  input wire led_scan_pkg::cmd_word_t i_cmd_word,
  input wire logic i_multiplex_clock_input,
  input wire logic i_use_external_clock,
  output logic [7:0] o_digit_enable,
  output logic [7:0] o_segments,
  output logic o_drive_en
);
  localparam int TW = $clog2(DIGIT_TICKS);
  // Sized to hold the count itself, so a power-of-two period cannot wrap to zero
  localparam int BW = $clog2(SLOW_TICKS + 1);
  localparam int STEP_TICKS = DIGIT_TICKS / led_scan_pkg::DUTY_STEPS;

  logic [7:0] decode_r;
  logic [3:0] intensity_r;
  logic [2:0] scan_limit_r;
  led_scan_pkg::config_t config_r;
  logic test_r;
  logic [7:0] first_data_plane_r [8];
  logic [7:0] second_data_plane_r [8];
  logic [TW-1:0] tick_cnt_r;
  logic [2:0] digit_r;
  logic [BW-1:0] blink_cnt_r;
  logic blink_phase_r;

  logic osc_tick;
  logic [4:0] cmd_group;
  logic [2:0] cmd_digit;
  logic wr_plane0, wr_plane1;
  logic cfg_wr, timing_clear, limit_wr, test_wr, plane_clear;
  led_scan_pkg::config_t cfg_in;
  logic running, advance, digit_end;
  logic [2:0] limit;
  logic [BW-1:0] half_ticks;
  logic [7:0] scan_byte;
  logic [6:0] font_seg;
  logic [7:0] seg_word;
  logic [3:0] duty;
  logic [TW:0] on_ticks;
  logic lit;
  logic plane_any;

  mux_clock_source #(
    .RC_DIV(RC_DIV),
    .FAILSAFE(FAILSAFE)
  ) u_clock_source (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_multiplex_clock_input(i_multiplex_clock_input),
    .i_use_external(i_use_external_clock),
    .o_osc_tick(osc_tick)
  );

  // Command decode
  assign cmd_group = i_cmd_word.addr[7:3];
  assign cmd_digit = i_cmd_word.addr[2:0];
  assign cfg_in = led_scan_pkg::config_t'(i_cmd_word.data);
  assign wr_plane0 = i_cs_rise && (cmd_group == led_scan_pkg::CMD_PLANE0_BASE ||
                                   cmd_group == led_scan_pkg::CMD_BOTH_BASE);
  assign wr_plane1 = i_cs_rise && (cmd_group == led_scan_pkg::CMD_PLANE1_BASE ||
                                   cmd_group == led_scan_pkg::CMD_BOTH_BASE);
  assign cfg_wr = i_cs_rise && i_cmd_word.addr == led_scan_pkg::CMD_CONFIG;
  assign timing_clear = cfg_wr && cfg_in.timing_reset;
  assign plane_clear = cfg_wr && cfg_in.global_clear;
  assign limit_wr = i_cs_rise && i_cmd_word.addr == led_scan_pkg::CMD_SCAN_LIMIT;
  assign test_wr = i_cs_rise && i_cmd_word.addr == led_scan_pkg::CMD_TEST;

  // Control registers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      decode_r <= led_scan_pkg::DECODE_RST;
      intensity_r <= led_scan_pkg::INTENSITY_RST;
      scan_limit_r <= led_scan_pkg::SCAN_LIMIT_RST;
      config_r <= led_scan_pkg::config_t'(led_scan_pkg::CONFIG_RST);
      test_r <= 1'b0;
    end else if (i_cs_rise) begin
      unique case (i_cmd_word.addr)
        led_scan_pkg::CMD_DECODE: decode_r <= i_cmd_word.data;
        led_scan_pkg::CMD_INTENSITY: intensity_r <= i_cmd_word.data[3:0];
        led_scan_pkg::CMD_SCAN_LIMIT: scan_limit_r <= i_cmd_word.data[2:0];
        led_scan_pkg::CMD_CONFIG: config_r <= cfg_in;
        led_scan_pkg::CMD_TEST: test_r <= i_cmd_word.data[0];
        default: ;
      endcase
    end
  end

  // Digit planes: written here, seen by the scan path from the next cycle
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        first_data_plane_r[i] <= 8'h00;
        second_data_plane_r[i] <= 8'h00;
      end
    end else if (plane_clear) begin
      for (int i = 0; i < 8; i++) begin
        first_data_plane_r[i] <= 8'h00;
        second_data_plane_r[i] <= 8'h00;
      end
    end else begin
      if (wr_plane0) begin
        first_data_plane_r[cmd_digit] <= i_cmd_word.data;
      end
      if (wr_plane1) begin
        second_data_plane_r[cmd_digit] <= i_cmd_word.data;
      end
    end
  end

  // Any lit byte left in either plane
  always_comb begin
    plane_any = 1'b0;
    for (int i = 0; i < 8; i++) begin
      plane_any = plane_any | (|first_data_plane_r[i]) | (|second_data_plane_r[i]);
    end
  end

  // Test mode runs even in shutdown; oscillator ticks are ignored otherwise
  assign running = config_r.run | test_r;
  assign advance = running & osc_tick;
  assign limit = test_r ? 3'h7 : scan_limit_r;
  assign digit_end = tick_cnt_r == TW'(DIGIT_TICKS - 1);

  // Digit slot timer and digit counter
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_r <= '0;
      digit_r <= 3'h0;
    end else if (timing_clear || limit_wr || test_wr) begin
      // Restarting on a new limit or on leaving test keeps the digit index inside the limit
      tick_cnt_r <= '0;
      digit_r <= 3'h0;
    end else if (advance) begin
      if (digit_end) begin
        tick_cnt_r <= '0;
        digit_r <= (digit_r >= limit) ? 3'h0 : digit_r + 3'h1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // Blink phase timer
  assign half_ticks = config_r.blink_fast ? BW'(FAST_TICKS) : BW'(SLOW_TICKS);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blink_cnt_r <= '0;
      blink_phase_r <= 1'b0;
    end else if (timing_clear) begin
      blink_cnt_r <= '0;
      blink_phase_r <= 1'b0;
    end else if (advance) begin
      if (blink_cnt_r >= half_ticks - 1'b1) begin
        blink_cnt_r <= '0;
        blink_phase_r <= ~blink_phase_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 1'b1;
      end
    end
  end

  // Segment data for the digit on scan
  assign scan_byte = (config_r.blink_en && blink_phase_r) ?
                     second_data_plane_r[digit_r] : first_data_plane_r[digit_r];

  hex_font_decode u_font (
    .i_nibble(scan_byte[3:0]),
    .o_segments(font_seg)
  );

  // Bit order dp,a..g matches the font output, so raw data passes unchanged
  assign seg_word = decode_r[digit_r] ? {scan_byte[7], font_seg} : scan_byte;

  assign duty = test_r ? led_scan_pkg::DUTY_TEST :
                (intensity_r == led_scan_pkg::DUTY_MAX) ? led_scan_pkg::DUTY_MAX : intensity_r + 4'h1;
  assign on_ticks = (TW + 1)'(int'(duty) * STEP_TICKS);
  assign lit = running && ({1'b0, tick_cnt_r} < on_ticks);

  // Drivers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_digit_enable <= 8'h00;
      o_segments <= 8'h00;
      o_drive_en <= 1'b0;
    end else begin
      o_drive_en <= running;
      o_digit_enable <= lit ? (8'h01 << digit_r) : 8'h00;
      o_segments <= !lit ? 8'h00 : test_r ? 8'hff : seg_word;
    end
  end

  sequence s_cfg_shutdown;
    cfg_wr && !cfg_in.run && !test_r && !(i_cmd_word.addr == led_scan_pkg::CMD_TEST);
  endsequence

  property p_shutdown_blank;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_cfg_shutdown ##1 (!test_r)[*2] |-> !o_drive_en && o_segments == 8'h00 && o_digit_enable == 8'h00;
  endproperty
  a_shutdown_blank: assert property (p_shutdown_blank) else $error("Shutdown left drivers active");

  property p_test_all_on;
    @(posedge i_clock) disable iff (i_sys_rst)
      $past(test_r) && $past(lit) |-> o_segments == 8'hff && o_drive_en;
  endproperty
  a_test_all_on: assert property (p_test_all_on) else $error("Test mode did not light all segments");

  property p_blink_off_plane0;
    @(posedge i_clock) disable iff (i_sys_rst)
      !config_r.blink_en |-> scan_byte == first_data_plane_r[digit_r];
  endproperty
  a_blink_off_plane0: assert property (p_blink_off_plane0) else $error("Second plane shown with blink off");

  property p_scan_limit;
    @(posedge i_clock) disable iff (i_sys_rst)
      !test_r |-> digit_r <= scan_limit_r;
  endproperty
  a_scan_limit: assert property (p_scan_limit) else $error("Digit index beyond scan limit");

  property p_timing_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
      timing_clear |=> tick_cnt_r == '0 && digit_r == 3'h0 && blink_cnt_r == '0 && !blink_phase_r;
  endproperty
  a_timing_clear: assert property (p_timing_clear) else $error("Timing not cleared by T bit");

  property p_global_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
      plane_clear |=> !plane_any;
  endproperty
  a_global_clear: assert property (p_global_clear) else $error("Planes not cleared by R bit");

  property p_plane0_only;
    @(posedge i_clock) disable iff (i_sys_rst)
      wr_plane0 && !wr_plane1 && !plane_clear |=>
        first_data_plane_r[$past(cmd_digit)] == $past(i_cmd_word.data) &&
        second_data_plane_r[$past(cmd_digit)] == $past(second_data_plane_r[cmd_digit]);
  endproperty
  a_plane0_only: assert property (p_plane0_only) else $error("First-plane write disturbed second plane");

  property p_decimal_point;
    @(posedge i_clock) disable iff (i_sys_rst)
      seg_word[7] == scan_byte[7];
  endproperty
  a_decimal_point: assert property (p_decimal_point) else $error("Decimal point not from bit seven");

  property p_duty_full;
    @(posedge i_clock) disable iff (i_sys_rst)
      running && !test_r && intensity_r == 4'hf && tick_cnt_r == TW'(DIGIT_TICKS - 1) |-> !lit;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("Blanking slot missing at full intensity");

  property p_strobe_onehot;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_digit_enable != 8'h00 |-> $onehot(o_digit_enable);
  endproperty
  a_strobe_onehot: assert property (p_strobe_onehot) else $error("More than one digit strobe active");

  property p_dark_segments;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_digit_enable == 8'h00 |-> o_segments == 8'h00;
  endproperty
  a_dark_segments: assert property (p_dark_segments) else $error("Segments driven with no digit strobe");

  property p_slot_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      advance && !digit_end && !timing_clear && !limit_wr && !test_wr |=> digit_r == $past(digit_r);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("Digit changed before its slot ended");
endmodule
`default_nettype wire

// *** host_cmd_model.sv ***
/*
  Host side of the command port: queues 16-bit command words and applies
  them one per cs-rise pulse, back to back or with idle gaps.
  Assumes the controller samples both signals on the rising i_clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  output logic o_cs_rise = 1'b0,
  output var led_scan_pkg::cmd_word_t o_cmd_word = 16'h0000
);
  led_scan_pkg::cmd_word_t q[$];
  int gap = 0;
  int idle = 0;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cs_rise <= 1'b0;
      idle <= 0;
    end else if (q.size() != 0 && idle >= gap) begin
      o_cs_rise <= 1'b1;
      o_cmd_word <= q.pop_front();
      idle <= 0;
    end else begin
      o_cs_rise <= 1'b0;
      // Idle word keeps changing so a stale word can never look valid
      o_cmd_word <= ~o_cmd_word;
      idle <= idle + 1;
    end
  end
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    q.push_back({a, (a == led_scan_pkg::CMD_CONFIG) ? (d & 8'hfd) : d});
  endtask
endmodule
`default_nettype wire

// *** led_scan_blink_decode_control_tb.sv ***
/*
  Self-checking bench for led_scan_ctrl with shortened counts.
  Commands come from host_cmd_model; a reference of planes and
  registers predicts the segment lines of whichever digit is lit.
*/
`timescale 1ns/1ps
`default_nettype none
module led_scan_blink_decode_control_tb;
  localparam logic [6:0] FONT [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
    7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3f, 7'h4f, 7'h47};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_rise;
  led_scan_pkg::cmd_word_t cmd_word;
  logic mux_in = 1'b0;
  logic use_ext = 1'b0;
  logic tog = 1'b0;
  logic [7:0] digit_en;
  logic [7:0] segs;
  logic drive_en;
  logic [7:0] p0 [8] = '{default: 8'h00};
  logic [7:0] p1 [8] = '{default: 8'h00};
  logic [7:0] dec = 8'h00;
  logic [7:0] cfg = 8'h00;
  logic tst = 1'b0;
  logic [7:0] seen = 8'h00;
  logic saw1 = 1'b0;
  logic [31:0] rnd = 32'h22b92f63;
  int num_errors = 0;
  int check_count = 0;
  int stl = 0;
  int run = 0;
  int last_run = 0;

  host_cmd_model host (.i_clock(clock), .i_sys_rst(sys_rst), .o_cs_rise(cs_rise), .o_cmd_word(cmd_word));
  led_scan_ctrl #(.DIGIT_TICKS(32), .SLOW_TICKS(64), .FAST_TICKS(32), .RC_DIV(2), .FAILSAFE(40)) dut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_cs_rise(cs_rise), .i_cmd_word(cmd_word),
    .i_multiplex_clock_input(mux_in), .i_use_external_clock(use_ext),
    .o_digit_enable(digit_en), .o_segments(segs), .o_drive_en(drive_en));

  initial forever #5 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic logic [7:0] seg_exp(input int d, input logic pl);
    logic [7:0] v;
    v = pl ? p1[d] : p0[d];
    return dec[d] ? {v[7], FONT[v[3:0]]} : v;
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    host.send(a, d);
    if (a == led_scan_pkg::CMD_DECODE) dec = d;
    if (a == led_scan_pkg::CMD_CONFIG) cfg = d & 8'hfd;
    if (a == led_scan_pkg::CMD_TEST) tst = d[0];
    if (a[7:3] == led_scan_pkg::CMD_PLANE0_BASE || a[7:3] == led_scan_pkg::CMD_BOTH_BASE) p0[a[2:0]] = d;
    if (a[7:3] == led_scan_pkg::CMD_PLANE1_BASE || a[7:3] == led_scan_pkg::CMD_BOTH_BASE) p1[a[2:0]] = d;
    if (a == led_scan_pkg::CMD_CONFIG && d[5]) begin
      p0 = '{default: 8'h00};
      p1 = '{default: 8'h00};
    end
  endtask

  task automatic wait_q();
    int n = 0;
    while (host.q.size() != 0 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (host.q.size() != 0) begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic scan_check(input logic [2:0] l, input int cyc);
    wait_q();
    repeat (20) @(negedge clock);
    seen = 8'h00;
    repeat (cyc) @(negedge clock);
    chk("scan", seen, 8'hff >> (3'h7 - l));
  endtask

  task automatic rand_round(input int gap);
    logic [7:0] a;
    host.gap = gap;
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      // Code 00 becomes a no-op, which must change nothing
      a = (rnd[6:5] == 2'b00) ? led_scan_pkg::CMD_NOOP : {1'b0, rnd[6:5], 2'b00, rnd[2:0]};
      cmd(a, rnd[15:8]);
    end
    cmd(led_scan_pkg::CMD_DECODE, rnd[23:16]);
    wait_q();
    repeat (700) @(negedge clock);
  endtask

  always @(posedge clock) begin
    mux_in <= tog ? ~mux_in : mux_in;
  end

  // Reference compare; skipped while a command is still on its way in
  always @(negedge clock) begin
    int di;
    di = 0;
    // Counted here so a word queued in this same step already blocks the compare
    stl = (cs_rise || host.q.size() != 0) ? 0 : stl + 1;
    if (digit_en != 8'h00) begin
      run = run + 1;
    end else begin
      if (run != 0) last_run = run;
      run = 0;
    end
    if (!sys_rst && stl > 3) begin
      chk("drive_en", drive_en, cfg[0] | tst);
      if (!cfg[0] && !tst) chk("dark", digit_en, 8'h00);
      for (int i = 0; i < 8; i++) begin
        if (digit_en[i]) di = i;
      end
      if (digit_en != 8'h00) begin
        seen[di] = 1'b1;
        chk("onehot", $onehot(digit_en), 1'b1);
        if (tst) begin
          chk("test_seg", segs, 8'hff);
        end else if (!cfg[3] || segs === seg_exp(di, 1'b0)) begin
          chk("seg", segs, seg_exp(di, 1'b0));
        end else begin
          saw1 = 1'b1;
          chk("seg_p1", segs, seg_exp(di, 1'b1));
        end
      end
    end
  end

  initial begin
    int v;
    int n;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (50) @(negedge clock);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h01);
    scan_check(3'h4, 1100);
    cmd(led_scan_pkg::CMD_SCAN_LIMIT, 8'hf7);
    for (int r = 0; r < 6; r++) rand_round(r % 3);
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 15 : ((i == 3) ? 14 : i * 5);
      @(posedge clock);
      use_ext <= i[0];
      tog <= i[0];
      cmd(led_scan_pkg::CMD_INTENSITY, {4'ha, v[3:0]});
      wait_q();
      repeat (300) @(negedge clock);
      chk("lit", last_run, ((v == 15) ? 15 : v + 1) * 4);
    end
    repeat (37) @(negedge clock);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h11);
    wait_q();
    repeat (3) @(negedge clock);
    chk("restart", digit_en, 8'h01);
    cmd(led_scan_pkg::CMD_SCAN_LIMIT, 8'h00);
    cmd(8'h20, 8'h0f);
    cmd(8'h40, 8'hf0);
    cmd(led_scan_pkg::CMD_DECODE, 8'h00);
    for (int b = 0; b < 2; b++) begin
      cmd(led_scan_pkg::CMD_CONFIG, b ? 8'h0f : 8'h0b);
      wait_q();
      saw1 = 1'b0;
      repeat (600) @(negedge clock);
      chk("blink_alt", saw1, 1'b1);
    end
    cmd(led_scan_pkg::CMD_CONFIG, 8'h19);
    wait_q();
    repeat (3) @(negedge clock);
    chk("phase0", segs, 8'h0f);
    n = 0;
    while (segs !== 8'hf0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("slow_half", n inside {[126:130]}, 1'b1);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h1d);
    wait_q();
    repeat (3) @(negedge clock);
    chk("phase0_fast", segs, 8'h0f);
    n = 0;
    while (segs !== 8'hf0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("fast_half", n inside {[62:66]}, 1'b1);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h21);
    wait_q();
    repeat (300) @(negedge clock);
    cmd(led_scan_pkg::CMD_SCAN_LIMIT, 8'h01);
    @(posedge clock);
    use_ext <= 1'b1;
    tog <= 1'b0;
    scan_check(3'h1, 3000);
    cmd(led_scan_pkg::CMD_SCAN_LIMIT, 8'h07);
    rand_round(0);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h00);
    wait_q();
    repeat (300) @(negedge clock);
    cmd(led_scan_pkg::CMD_TEST, 8'hfe);
    cmd(led_scan_pkg::CMD_TEST, 8'h01);
    scan_check(3'h7, 12000);
    cmd(led_scan_pkg::CMD_TEST, 8'h00);
    cmd(led_scan_pkg::CMD_CONFIG, 8'h01);
    wait_q();
    repeat (3000) @(negedge clock);
    end_of_test();
  end
endmodule
`default_nettype wire
